// ### core/mwf_regs.vh
`ifndef MWF_REGS_VH
`define MWF_REGS_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MWF_OFS_MAC_CONFIG   13'h1000
`define MWF_OFS_FLOW_CTRL    13'h1018
`define MWF_OFS_DEBUG        13'h1024
`define MWF_OFS_WAKE_WINDOW  13'h1028
`define MWF_OFS_PMT_CSR      13'h102c
`define MWF_OFS_INT_STATUS   13'h1038
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MWF_CFG_FULL_DUPLEX  11
`define MWF_FC_TRIGGER       0
`define MWF_FC_TX_FC_EN      1
`define MWF_DBG_RX_ENGINE    0
`define MWF_DBG_RX_FFC_LO    1
`define MWF_DBG_RX_FWR       4
`define MWF_DBG_RX_RDST_LO   5
`define MWF_DBG_RX_FILL_LO   8
`define MWF_DBG_TX_ENGINE    16
`define MWF_DBG_TX_FCST_LO   17
`define MWF_DBG_TX_PAUSED    19
`define MWF_DBG_TX_RDST_LO   20
`define MWF_DBG_TX_FWR       22
`define MWF_DBG_TX_NEMPTY    24
`define MWF_DBG_TX_STFULL    25
`define MWF_PMT_RECEIVE_POWER_DOWN       0
`define MWF_PMT_MAGIC_EN     1
`define MWF_PMT_WAKE_EN      2
`define MWF_PMT_MAGIC_SEEN   5
`define MWF_PMT_WAKE_SEEN    6
`define MWF_PMT_UCAST        9
`define MWF_PMT_PTR_LO       24
`define MWF_PMT_PTR_RST      31
`define MWF_INT_PMT          3
// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define MWF_RST_WORD         32'h0000_0000
`define MWF_RST_PTR          3'h0
`define MWF_PTR_MAX          3'h7
`define MWF_CRC_INIT         16'hffff
`define MWF_CRC_POLY_REFL    16'ha001
`define MWF_MAGIC_SYNC       3'h6
`define MWF_MAGIC_ADDR_BYTES 7'h60
`define MWF_MASK_BITS        31
`endif

// ### core/mwf_top.v
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "mwf_regs.vh"

module mwf_top #(
  parameter ADDR_W = 13
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              reset,
  // Avalon-MM slave
  input  wire [ADDR_W-1:0] avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  // Transmit path status and control
  input  wire              tx_status_fifo_full,
  input  wire              tx_fifo_not_empty,
  input  wire              tx_fifo_writer_active,
  input  wire [1:0]        tx_fifo_reader_state,
  input  wire              tx_paused,
  input  wire [1:0]        tx_frame_ctrl_state,
  input  wire              tx_engine_active,
  input  wire              pause_frame_done,
  output wire              pause_frame_request,
  output wire              tx_schedule_allow,
  output reg               backpressure,
  output reg               jam_request,
  // Receive path status
  input  wire [1:0]        rx_fifo_fill_level,
  input  wire [1:0]        rx_fifo_reader_state,
  input  wire              rx_fifo_writer_active,
  input  wire [1:0]        rx_frame_ctrl_fifo_state,
  input  wire              rx_engine_active,
  // Receive byte stream from the MII engine
  input  wire              rx_frame_start,
  input  wire              rx_byte_valid,
  input  wire [7:0]        rx_byte,
  input  wire              rx_frame_end,
  input  wire              rx_frame_good,
  input  wire              rx_da_unicast_ok,
  input  wire [47:0]       station_addr,
  // Power management outputs
  output reg               rx_drop,
  output reg               pmt_event,
  output reg               power_mgmt_irq_status
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // One reflected CRC16 step over a byte
  function [15:0] crc16_byte;
    input [15:0] crc;
    input [7:0]  data;
    integer      k;
    reg   [15:0] c;
    begin
      c = crc ^ {8'h00, data};
      for (k = 0; k < 8; k = k + 1) begin
        if (c[0])
          c = (c >> 1) ^ `MWF_CRC_POLY_REFL;
        else
          c = c >> 1;
      end
      crc16_byte = c;
    end
  endfunction

  // Address byte n of the station address, first on the wire first
  function [7:0] addr_byte;
    input [47:0] addr;
    input [2:0]  n;
    begin
      case (n)
        3'h0:    addr_byte = addr[47:40];
        3'h1:    addr_byte = addr[39:32];
        3'h2:    addr_byte = addr[31:24];
        3'h3:    addr_byte = addr[23:16];
        3'h4:    addr_byte = addr[15:8];
        default: addr_byte = addr[7:0];
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  reg        bus_ack;
  wire       bus_req = avs_read | avs_write;
  wire       wr_go   = avs_write & bus_ack;
  wire       rd_go   = avs_read & bus_ack;
  wire       hit_cfg = (avs_address == `MWF_OFS_MAC_CONFIG);
  wire       hit_fc  = (avs_address == `MWF_OFS_FLOW_CTRL);
  wire       hit_win = (avs_address == `MWF_OFS_WAKE_WINDOW);
  wire       hit_pmt = (avs_address == `MWF_OFS_PMT_CSR);

  assign avs_waitrequest = bus_req & ~bus_ack;

  // Ack toggles so each request is answered on its second cycle
  always @(posedge clk_sys) begin
    if (reset)
      bus_ack <= 1'b0;
    else
      bus_ack <= bus_req & ~bus_ack;
  end

  // ----------------------------------------------------------------
  // Configuration and flow control
  // ----------------------------------------------------------------
  reg  full_duplex;
  reg  tx_fc_en;
  reg  fc_trigger;
  wire wr_trig = wr_go & hit_fc & avs_writedata[`MWF_FC_TRIGGER];

  // Trigger is self-clearing in full duplex, plain bit in half duplex
  always @(posedge clk_sys) begin
    if (reset) begin
      full_duplex <= 1'b0;
      tx_fc_en    <= 1'b0;
      fc_trigger  <= 1'b0;
    end else begin
      if (wr_go & hit_cfg)
        full_duplex <= avs_writedata[`MWF_CFG_FULL_DUPLEX];
      if (wr_go & hit_fc)
        tx_fc_en <= avs_writedata[`MWF_FC_TX_FC_EN];
      if (full_duplex) begin
        if (wr_trig & ~fc_trigger & avs_writedata[`MWF_FC_TX_FC_EN])
          fc_trigger <= 1'b1;
        else if (fc_trigger & (pause_frame_done | ~tx_fc_en))
          fc_trigger <= 1'b0;
      end else if (wr_go & hit_fc) begin
        fc_trigger <= avs_writedata[`MWF_FC_TRIGGER];
      end
    end
  end

  // Pause frame held as a level until the transmitter reports done
  assign pause_frame_request = full_duplex & tx_fc_en & fc_trigger;
  assign tx_schedule_allow   = ~(full_duplex & tx_paused);

  // Backpressure and jam on each new frame in half duplex only
  always @(posedge clk_sys) begin
    if (reset) begin
      backpressure <= 1'b0;
      jam_request  <= 1'b0;
    end else begin
      backpressure <= ~full_duplex & tx_fc_en & fc_trigger;
      jam_request  <= ~full_duplex & tx_fc_en & fc_trigger & rx_frame_start;
    end
  end

  // ----------------------------------------------------------------
  // Debug status word
  // ----------------------------------------------------------------
  wire [31:0] debug_word;
  assign debug_word = {6'h00,
                       tx_status_fifo_full,
                       tx_fifo_not_empty,
                       1'b0,
                       tx_fifo_writer_active,
                       tx_fifo_reader_state,
                       full_duplex & tx_paused,
                       tx_frame_ctrl_state,
                       tx_engine_active,
                       6'h00,
                       rx_fifo_fill_level,
                       1'b0,
                       rx_fifo_reader_state,
                       rx_fifo_writer_active,
                       1'b0,
                       rx_frame_ctrl_fifo_state,
                       rx_engine_active};

  // ----------------------------------------------------------------
  // Wake-up filter store behind the pointer
  // ----------------------------------------------------------------
  reg  [31:0] filt_mem [0:7];
  reg  [2:0]  filt_ptr;
  wire        ptr_rst = wr_go & hit_pmt & avs_writedata[`MWF_PMT_PTR_RST];
  integer     m;

  // Window writes land at the pointer, which then steps and wraps at 7
  always @(posedge clk_sys) begin
    if (reset) begin
      filt_ptr <= `MWF_RST_PTR;
      for (m = 0; m < 8; m = m + 1)
        filt_mem[m] <= `MWF_RST_WORD;
    end else if (ptr_rst) begin
      filt_ptr <= `MWF_RST_PTR;
    end else if (wr_go & hit_win) begin
      filt_mem[filt_ptr] <= avs_writedata;
      filt_ptr <= (filt_ptr == `MWF_PTR_MAX) ? `MWF_RST_PTR : filt_ptr + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Per-frame byte position and multicast capture
  // ----------------------------------------------------------------
  reg  [10:0] byte_pos;
  reg         frame_mcast;

  // Byte counter restarts at each frame; first DA byte gives group bit
  always @(posedge clk_sys) begin
    if (reset) begin
      byte_pos    <= 11'h000;
      frame_mcast <= 1'b0;
    end else if (rx_frame_start) begin
      byte_pos <= 11'h000;
    end else if (rx_byte_valid) begin
      if (byte_pos == 11'h000)
        frame_mcast <= rx_byte[0];
      if (byte_pos != 11'h7ff)
        byte_pos <= byte_pos + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Four CRC16 pattern filters
  // ----------------------------------------------------------------
  wire [3:0] filt_hit;
  genvar     f;
  generate
    for (f = 0; f < 4; f = f + 1) begin : g_filt
      reg  [15:0] crc;
      wire [7:0]  ofs    = filt_mem[5][8*f +: 8];
      wire [10:0] rel    = byte_pos - {3'h0, ofs};
      wire        in_win = (byte_pos >= {3'h0, ofs}) &&
                           (rel < `MWF_MASK_BITS);
      wire [4:0]  j      = rel[4:0];
      wire        take   = in_win & filt_mem[f][j];
      wire [15:0] want   = filt_mem[6 + f/2][16*(f%2) +: 16];
      wire        en     = filt_mem[4][8*f];
      wire        mc_sel = filt_mem[4][8*f+3];

      // Masked bytes in the 31 bytes from the offset feed the CRC
      always @(posedge clk_sys) begin
        if (reset | rx_frame_start)
          crc <= `MWF_CRC_INIT;
        else if (rx_byte_valid & take)
          crc <= crc16_byte(crc, rx_byte);
      end

      assign filt_hit[f] = en & (crc == want) & (mc_sel == frame_mcast);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Magic packet detector: six 0xff then sixteen station addresses
  // ----------------------------------------------------------------
  reg  [2:0] mg_sync;
  reg  [6:0] mg_cnt;
  reg  [2:0] mg_pos;
  reg        mg_found;
  wire [7:0] mg_want = addr_byte(station_addr, mg_pos);

  // Any mismatch restarts the search, reusing an 0xff as sync
  always @(posedge clk_sys) begin
    if (reset | rx_frame_start) begin
      mg_sync  <= 3'h0;
      mg_cnt   <= 7'h00;
      mg_pos   <= 3'h0;
      mg_found <= 1'b0;
    end else if (rx_byte_valid & ~mg_found) begin
      if (mg_sync == `MWF_MAGIC_SYNC && rx_byte == mg_want) begin
        mg_cnt <= mg_cnt + 7'h01;
        mg_pos <= (mg_pos == 3'h5) ? 3'h0 : mg_pos + 3'h1;
        if (mg_cnt + 7'h01 == `MWF_MAGIC_ADDR_BYTES)
          mg_found <= 1'b1;
      end else if (rx_byte == 8'hff) begin
        if (mg_cnt != 7'h00)
          mg_sync <= 3'h1;
        else if (mg_sync != `MWF_MAGIC_SYNC)
          mg_sync <= mg_sync + 3'h1;
        mg_cnt <= 7'h00;
        mg_pos <= 3'h0;
      end else begin
        mg_sync <= 3'h0;
        mg_cnt  <= 7'h00;
        mg_pos  <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power management control and status
  // ----------------------------------------------------------------
  reg  power_down;
  reg  magic_en;
  reg  wake_en;
  reg  any_ucast;
  reg  magic_seen;
  reg  wake_seen;
  wire frame_ok   = rx_frame_end & rx_frame_good & power_down;
  wire magic_evt  = frame_ok & magic_en & mg_found;
  wire wake_evt   = frame_ok & ((wake_en & (|filt_hit)) |
                                (any_ucast & rx_da_unicast_ok));
  wire pmt_rd_clr = rd_go & hit_pmt;
  wire next_magic_seen = magic_evt | (magic_seen & ~pmt_rd_clr);
  wire next_wake_seen  = wake_evt | (wake_seen & ~pmt_rd_clr);

  // Seen flags: a new event wins over the read that clears them
  always @(posedge clk_sys) begin
    if (reset) begin
      power_down            <= 1'b0;
      magic_en              <= 1'b0;
      wake_en               <= 1'b0;
      any_ucast             <= 1'b0;
      magic_seen            <= 1'b0;
      wake_seen             <= 1'b0;
      power_mgmt_irq_status <= 1'b0;
      pmt_event             <= 1'b0;
      rx_drop               <= 1'b0;
    end else begin
      if (wr_go & hit_pmt) begin
        magic_en  <= avs_writedata[`MWF_PMT_MAGIC_EN];
        wake_en   <= avs_writedata[`MWF_PMT_WAKE_EN];
        any_ucast <= avs_writedata[`MWF_PMT_UCAST];
      end
      if (magic_evt | wake_evt)
        power_down <= 1'b0;
      else if (wr_go & hit_pmt & avs_writedata[`MWF_PMT_RECEIVE_POWER_DOWN])
        power_down <= 1'b1;
      magic_seen <= next_magic_seen;
      wake_seen  <= next_wake_seen;
      if (magic_evt | wake_evt)
        power_mgmt_irq_status <= 1'b1;
      else if (~next_magic_seen & ~next_wake_seen)
        power_mgmt_irq_status <= 1'b0;
      pmt_event <= magic_evt | wake_evt;
      rx_drop   <= power_down & ~(magic_evt | wake_evt);
    end
  end

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  reg [31:0] next_readdata;

  // Unmapped addresses read as zero
  always @* begin
    next_readdata = `MWF_RST_WORD;
    case (avs_address)
      `MWF_OFS_MAC_CONFIG:
        next_readdata[`MWF_CFG_FULL_DUPLEX] = full_duplex;
      `MWF_OFS_FLOW_CTRL: begin
        next_readdata[`MWF_FC_TRIGGER] = fc_trigger;
        next_readdata[`MWF_FC_TX_FC_EN] = tx_fc_en;
      end
      `MWF_OFS_DEBUG:
        next_readdata = debug_word;
      `MWF_OFS_WAKE_WINDOW:
        next_readdata = filt_mem[filt_ptr];
      `MWF_OFS_PMT_CSR: begin
        next_readdata[`MWF_PMT_RECEIVE_POWER_DOWN]     = power_down;
        next_readdata[`MWF_PMT_MAGIC_EN]   = magic_en;
        next_readdata[`MWF_PMT_WAKE_EN]    = wake_en;
        next_readdata[`MWF_PMT_MAGIC_SEEN] = magic_seen;
        next_readdata[`MWF_PMT_WAKE_SEEN]  = wake_seen;
        next_readdata[`MWF_PMT_UCAST]      = any_ucast;
        next_readdata[`MWF_PMT_PTR_LO +: 3] = filt_ptr;
      end
      `MWF_OFS_INT_STATUS:
        next_readdata[`MWF_INT_PMT] = power_mgmt_irq_status;
      default:
        next_readdata = `MWF_RST_WORD;
    endcase
  end

  // Read data registered in the wait cycle, valid when waitrequest drops
  always @(posedge clk_sys) begin
    if (reset)
      avs_readdata <= `MWF_RST_WORD;
    else if (avs_read & ~bus_ack)
      avs_readdata <= next_readdata;
  end

endmodule // mwf_top

// ### tb/mwf_top_properties.sv
`timescale 1ns/1ps
// ------
// Checks on flow and wake outputs
// ------
module mwf_top_properties (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Transmit side
  input wire tx_paused,
  input wire pause_frame_done,
  input wire pause_frame_request,
  input wire tx_schedule_allow,
  input wire backpressure,
  input wire jam_request,
  // Receive side
  input wire rx_frame_start,
  input wire rx_frame_end,
  input wire rx_drop,
  input wire pmt_event,
  input wire power_mgmt_irq_status
);
  // One clock domain for every check
  default clocking dck @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_pause_clr;
    pause_frame_done && pause_frame_request |=> !pause_frame_request;
  endproperty
  a_pause_clr: assert property (p_pause_clr) else $error("pause kept after done");
  property p_pause_bp; pause_frame_request |-> !backpressure; endproperty
  a_pause_bp: assert property (p_pause_bp) else $error("backpressure in full duplex");
  property p_sched; !tx_paused |-> tx_schedule_allow; endproperty
  a_sched: assert property (p_sched) else $error("schedule blocked unpaused");
  property p_jam; rx_frame_start && backpressure |=> jam_request; endproperty
  a_jam: assert property (p_jam) else $error("no jam on new frame");
  property p_evt_pulse; pmt_event |=> !pmt_event; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than a cycle");
  property p_evt_cause;
    pmt_event |-> $past(rx_frame_end) && $past(rx_drop) && !rx_drop;
  endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without frame end");
  property p_irq_set; pmt_event |-> power_mgmt_irq_status; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq status not set");
  property p_irq_rise; $rose(power_mgmt_irq_status) |-> pmt_event; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq status without event");
endmodule // mwf_top_properties

bind mwf_top mwf_top_properties i_props (
  .clk_sys(clk_sys), .reset(reset), .tx_paused(tx_paused),
  .pause_frame_done(pause_frame_done), .pause_frame_request(pause_frame_request),
  .tx_schedule_allow(tx_schedule_allow), .backpressure(backpressure),
  .jam_request(jam_request), .rx_frame_start(rx_frame_start), .rx_frame_end(rx_frame_end),
  .rx_drop(rx_drop), .pmt_event(pmt_event), .power_mgmt_irq_status(power_mgmt_irq_status)
);

// ### tb/mwf_phy_model.sv
`timescale 1ns/1ps
// ------
// Line side: pause completion and receive frames
// ------
module mwf_phy_model (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // Pause handshake
  input  wire       pause_frame_request,
  output reg        pause_frame_done = 1'b0,
  // Receive stream
  output reg        rx_frame_start = 1'b0,
  output reg        rx_byte_valid = 1'b0,
  output reg  [7:0] rx_byte = 8'h00,
  output reg        rx_frame_end = 1'b0,
  output reg        rx_frame_good = 1'b0,
  output reg        rx_da_unicast_ok = 1'b0
);
  int lat = 3;
  int cnt = 0;
  // Finish a requested pause frame lat+1 cycles after the request
  always @(posedge clk_sys) begin
    pause_frame_done <= 1'b0;
    if (reset || !pause_frame_request || pause_frame_done) begin
      cnt <= 0;
    end else if (cnt == lat) begin
      pause_frame_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Start pulse, bytes with a gap, end pulse; idle lines show junk
  task automatic send(input logic [7:0] b[$], input logic good, input logic uc);
    @(posedge clk_sys);
    rx_frame_start <= 1'b1;
    @(posedge clk_sys);
    rx_frame_start <= 1'b0;
    foreach (b[i]) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= b[i];
      @(posedge clk_sys);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~b[i];
      @(posedge clk_sys);
    end
    rx_frame_end <= 1'b1;
    rx_frame_good <= good;
    rx_da_unicast_ok <= uc;
    @(posedge clk_sys);
    rx_frame_end <= 1'b0;
    rx_frame_good <= ~good;
    rx_da_unicast_ok <= ~uc;
  endtask
endmodule // mwf_phy_model

// ### tb/mwf_top_bench.sv
`timescale 1ns/1ps
`include "mwf_regs.vh"
// ------
// Bench for flow, debug and wake logic
// ------
module mwf_top_bench;
  localparam logic [12:0] r_cfg = `MWF_OFS_MAC_CONFIG, r_fc = `MWF_OFS_FLOW_CTRL;
  localparam logic [12:0] r_dbg = `MWF_OFS_DEBUG, r_win = `MWF_OFS_WAKE_WINDOW;
  localparam logic [12:0] r_csr = `MWF_OFS_PMT_CSR, r_int = `MWF_OFS_INT_STATUS;
  localparam logic [47:0] st_addr = 48'h02a1_b2c3_d4e5;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [12:0] avs_address = 13'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [16:0] dbg = 17'h0;
  wire  [31:0] avs_readdata;
  wire  [7:0]  rx_byte;
  wire         avs_waitrequest, pause_frame_done, pause_frame_request, tx_schedule_allow;
  wire         backpressure, jam_request, rx_frame_start, rx_byte_valid, rx_frame_end;
  wire         rx_frame_good, rx_da_unicast_ok, rx_drop, pmt_event, power_mgmt_irq_status;
  int          fail_count = 0, n_checks = 0, cyc = 0, ev_cnt = 0, jam_cnt = 0;
  logic [7:0]  mag[$];
  logic [7:0]  fr[$];
  logic [31:0] win[8];

  mwf_top i_dut (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_status_fifo_full(dbg[0]),
    .tx_fifo_not_empty(dbg[1]), .tx_fifo_writer_active(dbg[2]),
    .tx_fifo_reader_state(dbg[4:3]), .tx_paused(dbg[5]), .tx_frame_ctrl_state(dbg[7:6]),
    .tx_engine_active(dbg[8]), .pause_frame_done(pause_frame_done),
    .pause_frame_request(pause_frame_request), .tx_schedule_allow(tx_schedule_allow),
    .backpressure(backpressure), .jam_request(jam_request), .rx_fifo_fill_level(dbg[10:9]),
    .rx_fifo_reader_state(dbg[12:11]), .rx_fifo_writer_active(dbg[13]),
    .rx_frame_ctrl_fifo_state(dbg[15:14]), .rx_engine_active(dbg[16]),
    .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_frame_end(rx_frame_end), .rx_frame_good(rx_frame_good),
    .rx_da_unicast_ok(rx_da_unicast_ok), .station_addr(st_addr), .rx_drop(rx_drop),
    .pmt_event(pmt_event), .power_mgmt_irq_status(power_mgmt_irq_status)
  );
  mwf_phy_model i_phy (
    .clk_sys(clk_sys), .reset(reset), .pause_frame_request(pause_frame_request),
    .pause_frame_done(pause_frame_done), .rx_frame_start(rx_frame_start),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
    .rx_frame_good(rx_frame_good), .rx_da_unicast_ok(rx_da_unicast_ok)
  );

  // Clock, pulse counters and run limit
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (pmt_event === 1'b1) ev_cnt++;
    if (jam_request === 1'b1) jam_cnt++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer, held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Expected debug word for status inputs d
  function automatic logic [31:0] dexp(input logic [16:0] d, input logic fd);
    dexp = {6'h0, d[0], d[1], 1'b0, d[2], d[4:3], d[5] & fd, d[7:6], d[8], 6'h0,
            d[10:9], 1'b0, d[12:11], d[13], 1'b0, d[15:14], d[16]};
  endfunction
  function automatic logic [15:0] crc16(input logic [7:0] b);
    crc16 = 16'hffff;
    for (int i = 0; i < 8; i++)
      crc16 = (crc16[0] ^ b[i]) ? (crc16 >> 1) ^ 16'ha001 : crc16 >> 1;
  endfunction

  task automatic t_reset();
    rdc(r_dbg, 32'h0);
    rdc(r_win, 32'h0);
    rdc(r_csr, 32'h0);
    rdc(r_fc, 32'h0);
    rdc(r_int, 32'h0);
    wr(13'h1100, 32'hffff_ffff);
    rdc(13'h1100, 32'h0);
  endtask
  // Walk every status input in both duplex modes; debug word is read only
  task automatic t_debug();
    for (int f = 0; f < 2; f++) begin
      wr(r_cfg, f << 11);
      for (int k = 0; k < 18; k++) begin
        dbg <= (k < 17) ? 17'h1 << k : 17'h1ffff;
        wr(r_dbg, 32'hffff_ffff);
        rdc(r_dbg, dexp(dbg, f[0]));
        chk(tx_schedule_allow, {31'h0, ~(f[0] & dbg[5])});
      end
    end
    dbg <= 17'h0;
    wr(r_cfg, 32'h0);
  endtask
  // Fill all eight window slots, then read back while stepping the pointer
  task automatic t_window();
    win = '{32'h1, 32'h12, 32'h34, 32'h7fff_ffff, 32'h1, 32'h0302_0100,
            {16'h1234, crc16(8'h02)}, 32'h5a5a_a5a5};
    for (int i = 0; i < 8; i++) wr(r_win, win[i]);
    for (int i = 0; i < 8; i++) begin
      rdc(r_csr, i << 24);
      rdc(r_win, win[i]);
      wr(r_win, win[i]);
    end
    wr(r_win, win[0]);
    wr(r_csr, 32'h8000_0000);
    rdc(r_csr, 32'h0);
  endtask
  task automatic frame(input logic good, input logic uc);
    i_phy.send(fr, good, uc);
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Power-down with magic enable: plain frame dropped, magic packet wakes
  task automatic t_magic();
    mag = {8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60};
    repeat (6) mag.push_back(8'hff);
    repeat (16) for (int k = 5; k >= 0; k--) mag.push_back(st_addr[k*8 +: 8]);
    wr(r_csr, 32'h3);
    ev_cnt = 0;
    fr = {8'h02, 8'h00, 8'h11};
    frame(1'b1, 1'b1);
    chk({ev_cnt[3:0], rx_drop}, 5'h01);
    fr = mag;
    frame(1'b1, 1'b1);
    chk({ev_cnt[3:0], rx_drop, power_mgmt_irq_status}, 6'h05);
    rdc(r_int, 32'h8);
    rdc(r_csr, 32'h22);
    rdc(r_csr, 32'h2);
    rdc(r_int, 32'h0);
  endtask
  // Wake filter match, bad frame ignored, magic gated off, global unicast
  task automatic t_wake();
    wr(r_csr, 32'h5);
    ev_cnt = 0;
    fr = mag;
    frame(1'b1, 1'b1);
    fr = {8'h02, 8'h99, 8'h77};
    frame(1'b0, 1'b1);
    chk({ev_cnt[3:0], rx_drop}, 5'h01);
    frame(1'b1, 1'b1);
    chk({ev_cnt[3:0], rx_drop}, 5'h02);
    rdc(r_csr, 32'h44);
    wr(r_csr, 32'h201);
    fr = {8'h04, 8'h99, 8'h77};
    frame(1'b1, 1'b1);
    chk(ev_cnt, 2);
    rdc(r_csr, 32'h240);
    rdc(r_csr, 32'h200);
  endtask
  // Backpressure and jam in half duplex, pause frames in full duplex
  task automatic t_flow();
    logic [31:0] q;
    int n;
    wr(r_fc, 32'h3);
    repeat (2) @(negedge clk_sys);
    chk(backpressure, 1);
    rdc(r_fc, 32'h3);
    jam_cnt = 0;
    fr = {8'h55};
    frame(1'b1, 1'b1);
    chk(jam_cnt, 1);
    wr(r_fc, 32'h1);
    repeat (2) @(negedge clk_sys);
    chk(backpressure, 0);
    wr(r_fc, 32'h0);
    wr(r_cfg, 32'h800);
    wr(r_fc, 32'h1);
    rdc(r_fc, 32'h0);
    chk(pause_frame_request, 0);
    for (int k = 0; k < 2; k++) begin
      i_phy.lat = k ? 2 : 20;
      wr(r_fc, 32'h3);
      chk(backpressure, 0);
      if (k == 0) rdc(r_fc, 32'h3);
      n = 0;
      do begin
        bus(1'b0, r_fc, 32'h0, q);
        n++;
      end while (q[0] !== 1'b0 && n < 30);
      chk(q, 32'h2);
      chk(pause_frame_request, 0);
    end
    wr(r_fc, 32'h0);
    wr(r_cfg, 32'h0);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_debug();
    t_window();
    t_magic();
    t_wake();
    t_flow();
    conclude();
  end
endmodule // mwf_top_bench
